// file: hw/ftp_trim_slave.sv
`timescale 1ns/1ps

// Overview of operation
// - Start: data falls while clock high
// - Address byte: address then direction bit
// - Only matching device acknowledges ninth clock
// - Direction one reads, zero writes
// - Instruction top bit picks trim array
// - Second array first disables first array
// - Park bit opens A, code kept
// - Parked writes stored, applied on leaving
// - Burn bit burns current wiper setting
// - Override allows change; clearing restores previous
// - Power-up: midscale or fuse setting
// - Low three instruction bits ignored
// - Nine clocks per byte, MSB first
// - Data changes only while clock low
// - Eight-bit code, 256 ladder positions
// - Read returns wiper code right away
// - Validation byte follows read data byte
// - Two status bits encode burn state
// - Stop: data rises while clock high
// - Repeated writes and reads in transaction
// - Address bits compared with strap pins
module ftp_trim_slave
    import ftp_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic fuse_trim1_blown,
    input wire logic fuse_trim2_blown,
    input wire logic [7:0] fuse_trim1_code,
    input wire logic [7:0] fuse_trim2_code,
    input wire logic fuse_test_ok,
    input wire logic fuse_error,
    output logic burn_req,
    output logic burn_array,
    output logic [7:0] burn_code,
    output logic [7:0] wiper_code,
    output logic wiper_park
);

    // ------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------
    logic start_tgl; // Flips on each start
    logic stop_tgl; // Flips on each stop

    // Start and stop seen on the data line
    ftp_cond_detect u_cond (
        .srst(srst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .start_tgl(start_tgl),
        .stop_tgl(stop_tgl)
    );

    // ------------------------------------------------------------
    // Link-side declarations
    // ------------------------------------------------------------
    ftp_link_state_type st_q; // Byte being moved
    ftp_link_state_type st_d;
    logic [3:0] cnt_q; // Bit count in byte, 8 is ack slot
    logic [3:0] cnt_d;
    logic [7:0] shift_q; // Incoming bits
    logic [7:0] shift_d;
    logic rw_q; // Direction of this transaction
    logic rw_d;
    logic ack_en_q; // Acknowledge the byte just taken
    logic ack_en_d;
    logic [7:0] instr_q; // Last instruction byte, held for system side
    logic [7:0] instr_d;
    logic [7:0] wdata_q; // Last wiper data byte, held for system side
    logic [7:0] wdata_d;
    logic [7:0] tx_q; // Byte being sent in read mode
    logic [7:0] tx_d;
    logic itgl_q; // Flips per instruction byte
    logic itgl_d;
    logic dtgl_q; // Flips per data byte
    logic dtgl_d;
    logic seen_q; // Copy of start toggle already handled
    logic seen_d;
    logic oe_q; // Data line pulled low
    logic oe_d;
    logic start_pend; // Start not yet handled
    logic [7:0] byte_full; // Byte including current bit
    logic addr_match; // Address byte is ours
    logic [1:0] strap_lk; // Straps on link clock
    logic [9:0] rd_lk; // Status and wiper on link clock
    logic [9:0] rd_sys; // Status and wiper, system side

    // Straps sampled on the link clock
    ftp_sync #(.W(2)) u_strap_sync (
        .clk(scl_in),
        .din({addr_strap_1, addr_strap_0}),
        .dout(strap_lk)
    );

    // Read-back values into the link domain
    ftp_sync #(.W(10)) u_rd_sync (
        .clk(scl_in),
        .din(rd_sys),
        .dout(rd_lk)
    );

    // ------------------------------------------------------------
    // Link receive side, rising clock edge
    // ------------------------------------------------------------
    // Start condition still waiting for the first bit
    assign start_pend = start_tgl != seen_q;
    // Byte completed by the bit on the line now
    assign byte_full = {shift_q[6:0], sda_in};
    // Upper address fixed, low two bits from straps
    assign addr_match = byte_full[7:1] == {FTP_ADDR_FIXED, strap_lk[1], strap_lk[0]};

    // Next state of the receive side
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        rw_d = rw_q;
        ack_en_d = ack_en_q;
        instr_d = instr_q;
        wdata_d = wdata_q;
        tx_d = tx_q;
        itgl_d = itgl_q;
        dtgl_d = dtgl_q;
        seen_d = seen_q;
        if (start_pend) begin
            // First address bit follows every start
            st_d = st_addr;
            cnt_d = FTP_FIRST_CNT;
            shift_d = {7'h00, sda_in};
            ack_en_d = 1'b0;
            seen_d = start_tgl;
        end else if (st_q == st_idle || st_q == st_skip) begin
            // Deaf until the next start
            st_d = st_q;
        end else if (cnt_q != FTP_ACK_SLOT) begin
            // Data bit, most significant first
            shift_d = byte_full;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == FTP_LAST_BIT) begin
                unique case (st_q)
                    st_addr: begin
                        // Acknowledge only our own address
                        ack_en_d = addr_match;
                        rw_d = byte_full[FTP_DIR_BIT];
                    end
                    st_instr: begin
                        // Whole byte kept; low bits never read
                        ack_en_d = 1'b1;
                        instr_d = byte_full;
                        itgl_d = ~itgl_q;
                    end
                    st_wdata: begin
                        // Each data byte is a new wiper code
                        ack_en_d = 1'b1;
                        wdata_d = byte_full;
                        dtgl_d = ~dtgl_q;
                    end
                    default: begin
                        // Read bytes are acknowledged by the master
                        ack_en_d = 1'b0;
                    end
                endcase
            end
        end else begin
            // Acknowledge slot: pick the next byte
            cnt_d = 4'h0;
            ack_en_d = 1'b0;
            unique case (st_q)
                st_addr: begin
                    if (!ack_en_q) begin
                        st_d = st_skip;
                    end else if (rw_q) begin
                        // Read: wiper code comes first
                        st_d = st_rdata;
                        tx_d = rd_lk[7:0];
                    end else begin
                        st_d = st_instr;
                    end
                end
                st_instr: begin
                    st_d = st_wdata;
                end
                st_wdata: begin
                    st_d = st_wdata;
                end
                st_rdata: begin
                    if (sda_in) begin
                        // No acknowledge ends the read
                        st_d = st_skip;
                    end else begin
                        st_d = st_rstat;
                        tx_d = {rd_lk[9:8], FTP_STATUS_PAD};
                    end
                end
                st_rstat: begin
                    if (sda_in) begin
                        st_d = st_skip;
                    end else begin
                        // Acknowledged: read again from the wiper
                        st_d = st_rdata;
                        tx_d = rd_lk[7:0];
                    end
                end
                default: begin
                    st_d = st_skip;
                end
            endcase
        end
    end

    // Receive registers, cleared by the system reset
    always_ff @(posedge scl_in or posedge srst) begin
        if (srst) begin
            st_q <= st_idle;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            rw_q <= 1'b0;
            ack_en_q <= 1'b0;
            instr_q <= 8'h00;
            wdata_q <= 8'h00;
            tx_q <= 8'h00;
            itgl_q <= 1'b0;
            dtgl_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            rw_q <= rw_d;
            ack_en_q <= ack_en_d;
            instr_q <= instr_d;
            wdata_q <= wdata_d;
            tx_q <= tx_d;
            itgl_q <= itgl_d;
            dtgl_q <= dtgl_d;
            seen_q <= seen_d;
        end
    end

    // ------------------------------------------------------------
    // Link transmit side, falling clock edge
    // ------------------------------------------------------------
    // Line driver changes only while the clock is low
    always_comb begin
        oe_d = 1'b0;
        if (start_pend || st_q == st_idle || st_q == st_skip) begin
            // Released while not addressed
            oe_d = 1'b0;
        end else if (cnt_q == FTP_ACK_SLOT) begin
            // Pull low through the ninth clock
            oe_d = ack_en_q;
        end else if (st_q == st_rdata || st_q == st_rstat) begin
            // Open drain: a one is a released line
            oe_d = ~tx_q[3'(FTP_LAST_BIT[2:0] - cnt_q[2:0])];
        end
    end

    // Driver register on the falling edge
    always_ff @(negedge scl_in or posedge srst) begin
        if (srst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
        end
    end

    assign sda_oe = oe_q;
    assign sda_out = FTP_SDA_LOW;

    // ------------------------------------------------------------
    // System-side declarations
    // ------------------------------------------------------------
    logic [2:0] ev_sync; // Stop, data and instruction toggles
    logic [2:0] ev_prev_q; // Toggles already handled
    logic [2:0] ev; // One-cycle events
    logic [7:0] wiper_q; // Wiper code latch
    logic [7:0] wiper_d;
    logic [7:0] saved_q; // Setting before override
    logic [7:0] saved_d;
    logic park_q; // Wiper parked on terminal B
    logic park_d;
    logic ovr_q; // Fuse override active
    logic ovr_d;
    logic arm_q; // Burn pending for this transaction
    logic arm_d;
    logic sel_q; // Array chosen by the instruction
    logic sel_d;
    logic preset_q; // Power-up preset still to load
    logic preset_d;
    logic breq_q; // Burn request pulse
    logic breq_d;
    logic barr_q; // Array being burned
    logic barr_d;
    logic [7:0] bcode_q; // Code being burned
    logic [7:0] bcode_d;
    logic [1:0] status_q; // Validation status
    logic [1:0] status_d;
    logic any_blown; // Some array holds a code
    logic burn_ok; // The chosen array may still be burned
    logic burn_status_hi; // Upper status bit
    logic burn_status_lo; // Lower status bit

    // Link events into the system clock
    ftp_sync #(.W(3)) u_ev_sync (
        .clk(clock),
        .din({stop_tgl, dtgl_q, itgl_q}),
        .dout(ev_sync)
    );

    assign ev = ev_sync ^ ev_prev_q;
    assign any_blown = fuse_trim1_blown | fuse_trim2_blown;
    // Second array burned disables the first
    assign burn_ok = sel_q ? ~fuse_trim2_blown : ~(fuse_trim1_blown | fuse_trim2_blown);
    assign rd_sys = {burn_status_hi, burn_status_lo, wiper_q};

    // ------------------------------------------------------------
    // Wiper and burn control
    // ------------------------------------------------------------
    // Next values of the system-side state
    always_comb begin
        wiper_d = wiper_q;
        saved_d = saved_q;
        park_d = park_q;
        ovr_d = ovr_q;
        arm_d = arm_q;
        sel_d = sel_q;
        preset_d = 1'b0;
        breq_d = 1'b0;
        barr_d = barr_q;
        bcode_d = bcode_q;
        if (preset_q) begin
            // Latest burned array, else midscale
            if (fuse_trim2_blown) begin
                wiper_d = fuse_trim2_code;
            end else if (fuse_trim1_blown) begin
                wiper_d = fuse_trim1_code;
            end else begin
                wiper_d = FTP_MID_CODE;
            end
            saved_d = wiper_d;
        end else begin
            if (ev[0]) begin
                // Instruction byte: park, burn and array choice
                park_d = instr_q[FTP_WIPER_PARK_POS];
                arm_d = instr_q[FTP_BURN_POS];
                sel_d = instr_q[FTP_SECOND_TRIM_SELECT_POS];
                if (instr_q[FTP_FUSE_OVERRIDE_POS] && !ovr_q) begin
                    // Remember the setting before overriding
                    ovr_d = 1'b1;
                    saved_d = wiper_q;
                end else if (!instr_q[FTP_FUSE_OVERRIDE_POS] && ovr_q) begin
                    // Leaving override restores it
                    ovr_d = 1'b0;
                    wiper_d = saved_q;
                end
            end
            if (ev[1] && (!any_blown || ovr_d)) begin
                // Stored even while parked
                wiper_d = wdata_q;
                if (!ovr_d) begin
                    saved_d = wdata_q;
                end
            end
            if (ev[2]) begin
                // Burn the wiper setting once the write ends
                breq_d = arm_q & burn_ok;
                barr_d = arm_q ? sel_q : barr_q;
                bcode_d = arm_q ? wiper_d : bcode_q;
                arm_d = 1'b0;
            end
        end
    end

    // Validation status from the fuse block
    always_comb begin
        if (fuse_trim2_blown) begin
            status_d = FTP_STAT_DONE;
        end else if (fuse_error) begin
            status_d = FTP_STAT_FATAL;
        end else if (!fuse_test_ok) begin
            status_d = FTP_STAT_TEST_FAIL;
        end else begin
            status_d = FTP_STAT_READY;
        end
    end

    assign burn_status_hi = status_q[1];
    assign burn_status_lo = status_q[0];

    // System registers with synchronous reset
    always_ff @(posedge clock) begin
        if (srst) begin
            ev_prev_q <= 3'h0;
            wiper_q <= FTP_MID_CODE;
            saved_q <= FTP_MID_CODE;
            park_q <= 1'b0;
            ovr_q <= 1'b0;
            arm_q <= 1'b0;
            sel_q <= 1'b0;
            preset_q <= 1'b1;
            breq_q <= 1'b0;
            barr_q <= 1'b0;
            bcode_q <= 8'h00;
            status_q <= FTP_STAT_READY;
        end else begin
            ev_prev_q <= ev_sync;
            wiper_q <= wiper_d;
            saved_q <= saved_d;
            park_q <= park_d;
            ovr_q <= ovr_d;
            arm_q <= arm_d;
            sel_q <= sel_d;
            preset_q <= preset_d;
            breq_q <= breq_d;
            barr_q <= barr_d;
            bcode_q <= bcode_d;
            status_q <= status_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wiper_code = wiper_q;
    assign wiper_park = park_q;
    assign burn_req = breq_q;
    assign burn_array = barr_q;
    assign burn_code = bcode_q;

endmodule

// file: hw/ftp_pkg.sv
package ftp_pkg;

    // ------------------------------------------------------------
    // Bus address and byte framing
    // ------------------------------------------------------------
    // Fixed upper five bits of the seven-bit slave address
    localparam logic [4:0] FTP_ADDR_FIXED = 5'h0b;
    // Direction bit position in the address byte (1 = read)
    localparam int FTP_DIR_BIT = 0;
    // Count of the last data bit in a byte
    localparam logic [3:0] FTP_LAST_BIT = 4'h7;
    // Count value of the acknowledge slot (ninth clock)
    localparam logic [3:0] FTP_ACK_SLOT = 4'h8;
    // Count loaded on the first clock after a start
    localparam logic [3:0] FTP_FIRST_CNT = 4'h1;
    // Level driven on the data line when the output is enabled
    localparam logic FTP_SDA_LOW = 1'b0;

    // ------------------------------------------------------------
    // Instruction byte fields
    // ------------------------------------------------------------
    localparam int FTP_SECOND_TRIM_SELECT_POS = 7;
    localparam int FTP_WIPER_PARK_POS = 6;
    localparam int FTP_BURN_POS = 5;
    localparam int FTP_ZERO_POS = 4;
    localparam int FTP_FUSE_OVERRIDE_POS = 3;

    // ------------------------------------------------------------
    // Wiper code and validation status
    // ------------------------------------------------------------
    // Midscale preset when no array has been burned
    localparam logic [7:0] FTP_MID_CODE = 8'h80;
    // Validation byte: status in the two top bits, rest zero
    localparam logic [5:0] FTP_STATUS_PAD = 6'h00;
    localparam logic [1:0] FTP_STAT_READY = 2'h0;
    localparam logic [1:0] FTP_STAT_TEST_FAIL = 2'h1;
    localparam logic [1:0] FTP_STAT_FATAL = 2'h2;
    localparam logic [1:0] FTP_STAT_DONE = 2'h3;

    // ------------------------------------------------------------
    // Link state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_instr,
        st_wdata,
        st_rdata,
        st_rstat,
        st_skip
    } ftp_link_state_type;

endpackage

// file: hw/ftp_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser, one per bit
module ftp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    logic [W-1:0] meta_q; // First stage, read only by the second
    logic [W-1:0] sync_q; // Second stage, safe to use

    // Both stages shift every rising edge
    always_ff @(posedge clk) begin
        meta_q <= din;
        sync_q <= meta_q;
    end

    assign dout = sync_q;

endmodule

// file: hw/ftp_cond_detect.sv
`timescale 1ns/1ps

// Start and stop detection, clocked by the data line itself
module ftp_cond_detect (
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic start_tgl,
    output logic stop_tgl
);

    // ------------------------------------------------------------
    // Toggles
    // ------------------------------------------------------------
    logic start_q; // Flips on every start
    logic start_d;
    logic stop_q; // Flips on every stop
    logic stop_d;

    // Flip only when the clock line is high
    always_comb begin
        start_d = scl_in ? ~start_q : start_q;
        stop_d = scl_in ? ~stop_q : stop_q;
    end

    // Falling data line marks a start
    always_ff @(negedge sda_in or posedge srst) begin
        if (srst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
        end
    end

    // Rising data line marks a stop
    always_ff @(posedge sda_in or posedge srst) begin
        if (srst) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
        end
    end

    assign start_tgl = start_q;
    assign stop_tgl = stop_q;

endmodule

// file: dv/ftp_trim_slave_assertions.sv
`timescale 1ns/1ps
module ftp_trim_slave_assertions
    import ftp_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic fuse_trim1_blown,
    input wire logic fuse_trim2_blown,
    input wire logic [7:0] fuse_trim1_code,
    input wire logic [7:0] fuse_trim2_code,
    input wire logic burn_req,
    input wire logic burn_array,
    input wire logic [7:0] burn_code,
    input wire logic [7:0] wiper_code,
    input wire logic wiper_park
);
    // ------------------------------------------------------------
    // Drive level seen at the last bus clock rise
    // ------------------------------------------------------------
    logic oe_hi_q; // Data line drive while bus clock high
    always_ff @(posedge scl_in or posedge srst) begin
        if (srst) begin
            oe_hi_q <= 1'b0;
        end else begin
            oe_hi_q <= sda_oe;
        end
    end
    property p_oe_stable; @(negedge scl_in) disable iff (srst) sda_oe == oe_hi_q; endproperty
    a_oe_stable: assert property (p_oe_stable) else $error("drive moved in clock high");
    property p_out_low; @(posedge clock) disable iff (srst) sda_out == FTP_SDA_LOW; endproperty
    a_out_low: assert property (p_out_low) else $error("data line driven high");
    property p_rst_vals; @(posedge clock) disable iff (srst)
        $fell(srst) |-> wiper_code == FTP_MID_CODE && !wiper_park && !burn_req; endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
    property p_preset; @(posedge clock) disable iff (srst) $fell(srst) |-> ##[1:3]
        wiper_code == (fuse_trim2_blown ? fuse_trim2_code
        : fuse_trim1_blown ? fuse_trim1_code : FTP_MID_CODE); endproperty
    a_preset: assert property (p_preset) else $error("bad power-up wiper");
    property p_park_keeps; @(posedge clock) disable iff (srst)
        $rose(wiper_park) |-> $stable(wiper_code); endproperty
    a_park_keeps: assert property (p_park_keeps) else $error("park changed code");
    property p_burn_pulse; @(posedge clock) disable iff (srst) burn_req |=> !burn_req; endproperty
    a_burn_pulse: assert property (p_burn_pulse) else $error("burn request too long");
    property p_burn_held; @(posedge clock) disable iff (srst)
        burn_req |=> $stable(burn_code) && $stable(burn_array); endproperty
    a_burn_held: assert property (p_burn_held) else $error("burn fields not held");
    property p_burn_code; @(posedge clock) disable iff (srst)
        burn_req |-> burn_code == wiper_code; endproperty
    a_burn_code: assert property (p_burn_code) else $error("burn code not wiper");
    property p_burn_refused; @(posedge clock) disable iff (srst) burn_req |->
        !fuse_trim2_blown && !(!burn_array && fuse_trim1_blown); endproperty
    a_burn_refused: assert property (p_burn_refused) else $error("illegal burn");
endmodule
bind ftp_trim_slave ftp_trim_slave_assertions ftp_trim_slave_assertions_i (.*);

// file: dv/ftp_master_model.sv
`timescale 1ns/1ps
// Bus master; clock stands high between frames
module ftp_master_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // ------------------------------------------------------------
    // Bit, frame and byte sequences, 48 ns per bit
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic bit_x(input logic b, output logic r);
        sda_drv = b;
        #12 scl = 1'b1;
        #12 r = sda;
        #12 scl = 1'b0;
        #12;
    endtask
    task automatic start_c();
        sda_drv = 1'b1;
        scl = 1'b1;
        #24 sda_drv = 1'b0;
        #24 scl = 1'b0;
        #12;
    endtask
    task automatic stop_c();
        sda_drv = 1'b0;
        #12 scl = 1'b1;
        #24 sda_drv = 1'b1;
        #24;
    endtask
    // Master ack level goes out in the ninth slot
    task automatic byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
            output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(mack, ack);
    endtask
endmodule

// file: dv/ftp_trim_slave_tb_top.sv
`timescale 1ns/1ps
module ftp_trim_slave_tb_top import ftp_pkg::*; ();
    // ------------------------------------------------------------
    // Signals, clock and bus wiring
    // ------------------------------------------------------------
    logic clock = 1'b0, srst = 1'b0, scl, sda_drv, sda, sda_out, sda_oe, ack;
    logic t1b = 1'b0, t2b = 1'b0, tok = 1'b1, ferr = 1'b0, burn_req, burn_array, wiper_park;
    logic [1:0] strap = 2'b10; // Strap pins {1, 0}
    logic [7:0] t1c = 8'h3c, t2c = 8'ha5, burn_code, wiper_code, c0, st, c1;
    int failures = 0, checked = 0, cycles = 0, burns = 0;
    assign sda = sda_drv & ~(sda_oe & ~sda_out); // Wired-AND with pull-up
    always #20 clock = ~clock;
    // Burn pulse count and hang guard
    always @(posedge clock) begin
        cycles++;
        if (burn_req === 1'b1) burns++;
        if (cycles == 6000) begin
            failures++;
            end_sim();
        end
    end
    ftp_master_model ftp_master_model_i (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    ftp_trim_slave ftp_trim_slave_i (.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
        .fuse_trim1_blown(t1b), .fuse_trim2_blown(t2b), .fuse_trim1_code(t1c),
        .fuse_trim2_code(t2c), .fuse_test_ok(tok), .fuse_error(ferr), .burn_req(burn_req),
        .burn_array(burn_array), .burn_code(burn_code), .wiper_code(wiper_code),
        .wiper_park(wiper_park));
    // ------------------------------------------------------------
    // Access tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write: address, instruction (bit 4 zero), n data bytes counting up
    task automatic wr(input logic [1:0] a, input logic [7:0] ins, input logic [7:0] d, input int n);
        logic [7:0] rx;
        logic k;
        ftp_master_model_i.start_c();
        ftp_master_model_i.byte_x({FTP_ADDR_FIXED, a, 1'b0}, 1'b1, rx, ack);
        ftp_master_model_i.byte_x(ins, 1'b1, rx, k);
        for (int i = 0; i < n; i++) ftp_master_model_i.byte_x(d + 8'(i), 1'b1, rx, k);
        ftp_master_model_i.stop_c();
        repeat (10) @(posedge clock);
    endtask
    // Read: wiper, status, wiper again then nack
    task automatic rd();
        logic k;
        ftp_master_model_i.start_c();
        ftp_master_model_i.byte_x({FTP_ADDR_FIXED, 2'b10, 1'b1}, 1'b1, c0, ack);
        ftp_master_model_i.byte_x(8'hff, 1'b0, c0, k);
        ftp_master_model_i.byte_x(8'hff, 1'b0, st, k);
        ftp_master_model_i.byte_x(8'hff, 1'b1, c1, k);
        ftp_master_model_i.stop_c();
        repeat (4) @(posedge clock);
    endtask
    task automatic end_sim();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        #1 srst = 1'b1; // Rising edge clears the link flops
        repeat (3) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        repeat (3) @(posedge clock);
        chk(wiper_code, FTP_MID_CODE);
        rd();
        chk({7'h0, ack}, 8'h00);
        chk(c0, FTP_MID_CODE);
        chk(c1, FTP_MID_CODE);
        wr(2'b01, 8'h00, 8'h11, 1);
        chk({7'h0, ack}, 8'h01);
        chk(wiper_code, FTP_MID_CODE);
        wr(2'b10, 8'h07, 8'h5a, 2);
        chk(wiper_code, 8'h5b);
        wr(2'b10, 8'h40, 8'h33, 1);
        chk({7'h0, wiper_park}, 8'h01);
        chk(wiper_code, 8'h33);
        wr(2'b10, 8'h00, 8'h77, 1);
        chk({7'h0, wiper_park}, 8'h00);
        wr(2'b10, 8'h20, 8'h77, 1);
        chk(8'(burns), 8'h01);
        chk(burn_code, 8'h77);
        chk({7'h0, burn_array}, 8'h00);
        @(negedge clock) {t1b, t1c} = {1'b1, 8'h77};
        wr(2'b10, 8'h00, 8'h11, 1);
        chk(wiper_code, 8'h77);
        wr(2'b10, 8'h08, 8'h11, 1);
        chk(wiper_code, 8'h11);
        wr(2'b10, 8'h00, 8'h22, 1);
        chk(wiper_code, 8'h77);
        wr(2'b10, 8'h20, 8'h44, 1);
        chk(8'(burns), 8'h01);
        wr(2'b10, 8'ha0, 8'h44, 1);
        chk(8'(burns), 8'h02);
        chk({7'h0, burn_array}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            @(negedge clock) {t2b, ferr, tok} = {i == 3, i == 2, i == 0};
            rd();
            chk(st, {2'(i), FTP_STATUS_PAD});
        end
        @(negedge clock) srst = 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        repeat (3) @(posedge clock);
        chk(wiper_code, 8'ha5);
        end_sim();
    end
endmodule
